// File: coax_rx_mgmt_regs.sv
// coax receiver register bank
//
// Function
// R1: read command returns phy word into input registers
// R2: write command sends output registers to phy
// R3: phy address is three bits plus pins
// R4: output word: low and high byte registers
// R5: input word: low and high byte registers
// R6: software writes zero to reserved bits
// R7: automatic mode enables link on phy link
// R8: manual mode enables from control bits 3,4
// R9: software writes ones to control bits 2:1
// R10: window is 65536 times segment count (code scales the live regWrData byte, not fecSegs_ff)
// R11: count-updated flag set at window end
// R12: zero segment count stops counter, clears flag
// R13: error total is three byte registers
// R14: error bytes read all ones until updated
// R15: seven-bit monotonic video gain field
// R16: writing zero count clears updated flag
// R17: link status bit follows phy link
// R18: phy link status is polled periodically
// R19: mdc period is eight reference periods
// R20: standard clause-22 frame format
// R21: one transaction per command bit rising edge
`timescale 1ns/1ps
module coax_rx_mgmt_regs
  import coax_rx_pkg::*;
#(
  parameter int POLL_PERIOD = POLL_CYCLES  // cycles between link polls
)
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // register port
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic [7:0]      regRdData,
  // address strap pins
  input  wire logic       phyAddrPinHi,
  input  wire logic       phyAddrPinLo,
  // management pins
  output logic            mdc,
  input  wire logic       mdioIn,
  output logic            mdioOut,
  output logic            mdioOeN,
  // decoder events
  input  wire logic       fecSegmentTick,
  input  wire logic       fecErrorTick,
  // link and analog controls
  output logic            coaxTxEnable,
  output logic            coaxRxEnable,
  output logic [6:0]      videoGainField
);
  initial if (POLL_PERIOD < FRAME_BITS * MDC_DIV) $error("poll period too short");

  // ==========================================
  // register storage
  logic        cmdRead_ff;      // read command bit
  logic        cmdWrite_ff;     // write command bit
  logic [2:0]  phyAddrHi_ff;    // upper phy address bits
  logic [4:0]  mgmtRegAddr_ff;  // target register address
  logic [7:0]  outLo_ff;        // outgoing word, low byte
  logic [7:0]  outHi_ff;        // outgoing word, high byte
  logic [15:0] inWord_ff;       // returned word
  logic [7:0]  linkCtrl_ff;     // link enable control
  logic [7:0]  fecSegs_ff;      // monitor segment count
  logic        phyLinkUp_ff;    // polled phy link status

  // ==========================================
  // pin synchronisers and engine handshake
  logic [1:0]  pinMeta_ff;      // first stage, pins
  logic [1:0]  pinSync_ff;      // second stage, pins
  logic        rdPend_ff;       // read request waiting
  logic        wrPend_ff;       // write request waiting
  logic        pollPend_ff;     // poll request waiting
  logic [31:0] pollCnt_ff;      // poll interval timer
  logic [1:0]  curOp_ff;        // running request
  logic        engStart;        // start pulse to engine
  logic        engRead;         // start carries a read
  logic [4:0]  engReg;          // register for this frame
  logic        engBusy;         // engine running
  logic        engDone;         // engine finished
  logic [15:0] engRdData;       // engine read word
  logic [4:0]  phyAddr;         // full phy address
  logic        fecRestart;      // segment count written
  logic [23:0] fecTotal;        // latched error total
  logic        fecUpdated;      // count-updated flag

  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b10,
    OP_POLL  = 2'b11
  } mgmt_op_t;

  assign phyAddr = {phyAddrHi_ff, pinSync_ff}; // R3

  // ==========================================
  // strap pins pass two flops before any use
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta_ff <= 2'b00;
      pinSync_ff <= 2'b00;
    end else begin
      pinMeta_ff <= {phyAddrPinHi, phyAddrPinLo};
      pinSync_ff <= pinMeta_ff;
    end
  end

  // ==========================================
  // writable registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmdRead_ff     <= 1'b0;
      cmdWrite_ff    <= 1'b0;
      phyAddrHi_ff   <= 3'h0;
      mgmtRegAddr_ff <= 5'h00;
      outLo_ff       <= RST_ZERO;
      outHi_ff       <= RST_ZERO;
      linkCtrl_ff    <= RST_ZERO;
      fecSegs_ff     <= RST_ZERO;
      videoGainField <= RST_VIDEO_GAIN;
    end else if (regWrEn) begin
      // reserved bits dropped, except in the link control register, which keeps all bits
      if (regAddr == ADDR_MGMT_CMD) begin
        cmdRead_ff   <= regWrData[CMD_READ_BIT];
        cmdWrite_ff  <= regWrData[CMD_WRITE_BIT];
        phyAddrHi_ff <= regWrData[CMD_PHY_LSB +: 3]; // R3
      end else if (regAddr == ADDR_MGMT_REG) begin
        mgmtRegAddr_ff <= regWrData[4:0];
      end else if (regAddr == ADDR_MGMT_OUT_LO) begin
        outLo_ff <= regWrData;
      end else if (regAddr == ADDR_MGMT_OUT_HI) begin
        outHi_ff <= regWrData;
      end else if (regAddr == ADDR_LINK_CTRL) begin
        // all bits kept for readback
        linkCtrl_ff <= regWrData;
      end else if (regAddr == ADDR_FEC_SEGMENTS) begin
        fecSegs_ff <= regWrData;
      end else if (regAddr == ADDR_VIDEO_GAIN) begin
        videoGainField <= regWrData[6:0]; // R15
      end
    end
  end

  assign fecRestart = regWrEn && (regAddr == ADDR_FEC_SEGMENTS);

  // ==========================================
  // command bit rising edges queue one frame
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdPend_ff <= 1'b0;
      wrPend_ff <= 1'b0;
    end else begin
      if (regWrEn && regAddr == ADDR_MGMT_CMD && regWrData[CMD_READ_BIT] && !cmdRead_ff) begin
        rdPend_ff <= 1'b1; // R21 R1
      end else if (engStart && rdPend_ff) begin
        rdPend_ff <= 1'b0;
      end
      if (regWrEn && regAddr == ADDR_MGMT_CMD && regWrData[CMD_WRITE_BIT] && !cmdWrite_ff) begin
        wrPend_ff <= 1'b1; // R21 R2
      end else if (engStart && !rdPend_ff && wrPend_ff) begin
        wrPend_ff <= 1'b0;
      end
    end
  end

  // ==========================================
  // poll timer; a poll waits behind software commands
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pollCnt_ff  <= 32'h0;
      pollPend_ff <= 1'b0;
    end else begin
      if (pollCnt_ff == 32'(POLL_PERIOD - 1)) begin
        pollCnt_ff  <= 32'h0;
        pollPend_ff <= 1'b1; // R18
      end else begin
        pollCnt_ff <= pollCnt_ff + 32'h1;
        if (engStart && !rdPend_ff && !wrPend_ff) begin
          pollPend_ff <= 1'b0;
        end
      end
    end
  end

  // ==========================================
  // arbitration: read, then write, then poll
  always_comb begin
    engStart = 1'b0;
    engRead  = 1'b0;
    engReg   = mgmtRegAddr_ff;
    if (!engBusy && curOp_ff == OP_NONE) begin
      if (rdPend_ff) begin
        engStart = 1'b1;
        engRead  = 1'b1;
      end else if (wrPend_ff) begin
        engStart = 1'b1;
      end else if (pollPend_ff) begin
        engStart = 1'b1;
        engRead  = 1'b1;
        engReg   = PHY_STATUS_REG; // R18
      end
    end
  end

  // running operation steers its result
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      curOp_ff <= OP_NONE;
    end else if (engStart) begin
      if (rdPend_ff) begin
        curOp_ff <= OP_READ;
      end else if (wrPend_ff) begin
        curOp_ff <= OP_WRITE;
      end else begin
        curOp_ff <= OP_POLL;
      end
    end else if (engDone) begin
      curOp_ff <= OP_NONE;
    end
  end

  // ==========================================
  // results: reads to input word, polls to link bit
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      inWord_ff    <= 16'h0;
      phyLinkUp_ff <= 1'b0;
    end else if (engDone) begin
      if (curOp_ff == OP_READ) begin
        inWord_ff <= engRdData; // R1 R5
      end else if (curOp_ff == OP_POLL) begin
        phyLinkUp_ff <= engRdData[BMSR_LINK_BIT]; // R17
      end
    end
  end

  mgmt_master u_mgmt (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .start   (engStart),
    .isRead  (engRead),
    .phyAddr (phyAddr),
    .regAddr (engReg),
    .wrData  ({outHi_ff, outLo_ff}),
    .busy    (engBusy),
    .done    (engDone),
    .rdData  (engRdData),
    .mdc     (mdc),
    .mdioIn  (mdioIn),
    .mdioOut (mdioOut),
    .mdioOeN (mdioOeN)
  );

  fec_err_counter u_fec (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .restart  (fecRestart),
    .segCount (regWrData),
    .segTick  (fecSegmentTick),
    .errTick  (fecErrorTick),
    .errTotal (fecTotal),
    .updated  (fecUpdated)
  );

  // ==========================================
  // link enables, automatic or manual
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      coaxTxEnable <= 1'b0;
      coaxRxEnable <= 1'b0;
    end else if (linkCtrl_ff[CTRL_MANUAL_BIT]) begin
      coaxTxEnable <= linkCtrl_ff[CTRL_TX_BIT]; // R8
      coaxRxEnable <= linkCtrl_ff[CTRL_RX_BIT]; // R8
    end else begin
      coaxTxEnable <= phyLinkUp_ff; // R7
      coaxRxEnable <= phyLinkUp_ff; // R7
    end
  end

  // ==========================================
  // read data, one cycle after the strobe
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      regRdData <= RST_ZERO;
    end else if (regRdEn) begin
      if (regAddr == ADDR_MGMT_CMD) begin
        regRdData <= {1'b0, phyAddrHi_ff, 2'b00, cmdWrite_ff, cmdRead_ff};
      end else if (regAddr == ADDR_MGMT_REG) begin
        regRdData <= {3'h0, mgmtRegAddr_ff};
      end else if (regAddr == ADDR_MGMT_OUT_LO) begin
        regRdData <= outLo_ff;
      end else if (regAddr == ADDR_MGMT_OUT_HI) begin
        regRdData <= outHi_ff;
      end else if (regAddr == ADDR_MGMT_IN_LO) begin
        regRdData <= inWord_ff[7:0]; // R5
      end else if (regAddr == ADDR_MGMT_IN_HI) begin
        regRdData <= inWord_ff[15:8]; // R5
      end else if (regAddr == ADDR_LINK_CTRL) begin
        regRdData <= linkCtrl_ff;
      end else if (regAddr == ADDR_FEC_SEGMENTS) begin
        regRdData <= fecSegs_ff;
      end else if (regAddr == ADDR_VIDEO_GAIN) begin
        regRdData <= {1'b0, videoGainField};
      end else if (regAddr == ADDR_FEC_ERR_B0) begin
        regRdData <= fecUpdated ? fecTotal[7:0] : ERR_INVALID; // R13 R14
      end else if (regAddr == ADDR_FEC_ERR_B1) begin
        regRdData <= fecUpdated ? fecTotal[15:8] : ERR_INVALID; // R13 R14
      end else if (regAddr == ADDR_FEC_ERR_B2) begin
        regRdData <= fecUpdated ? fecTotal[23:16] : ERR_INVALID; // R13 R14
      end else if (regAddr == ADDR_FEC_UPDATED) begin
        regRdData <= {7'h0, fecUpdated}; // R11
      end else if (regAddr == ADDR_STATUS) begin
        regRdData <= {4'h0, phyLinkUp_ff, 3'h0}; // R17
      end else begin
        // unmapped addresses read as zero
        regRdData <= RST_ZERO;
      end
    end
  end
endmodule

// File: coax_rx_pkg.sv
// constants of the coax receiver register bank
package coax_rx_pkg;
  // ==========================================
  // register offsets
  localparam logic [7:0] ADDR_MGMT_CMD      = 8'h1e;
  localparam logic [7:0] ADDR_MGMT_REG      = 8'h1f;
  localparam logic [7:0] ADDR_MGMT_OUT_LO   = 8'h20;
  localparam logic [7:0] ADDR_MGMT_OUT_HI   = 8'h21;
  localparam logic [7:0] ADDR_MGMT_IN_LO    = 8'h22;
  localparam logic [7:0] ADDR_MGMT_IN_HI    = 8'h23;
  localparam logic [7:0] ADDR_LINK_CTRL     = 8'h26;
  localparam logic [7:0] ADDR_FEC_SEGMENTS  = 8'h27;
  localparam logic [7:0] ADDR_VIDEO_GAIN    = 8'h30;
  localparam logic [7:0] ADDR_FEC_ERR_B0    = 8'h40;
  localparam logic [7:0] ADDR_FEC_ERR_B1    = 8'h41;
  localparam logic [7:0] ADDR_FEC_ERR_B2    = 8'h42;
  localparam logic [7:0] ADDR_FEC_UPDATED   = 8'h43;
  localparam logic [7:0] ADDR_STATUS        = 8'h44;
  // ==========================================
  // field positions
  localparam int CMD_READ_BIT    = 0;
  localparam int CMD_WRITE_BIT   = 1;
  localparam int CMD_PHY_LSB     = 4;
  localparam int CTRL_MANUAL_BIT = 0;
  localparam int CTRL_TX_BIT     = 3;
  localparam int CTRL_RX_BIT     = 4;
  localparam int STATUS_LINK_BIT = 3;
  localparam int BMSR_LINK_BIT   = 2;
  // ==========================================
  // reset values
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [6:0] RST_VIDEO_GAIN = 7'h2b;
  localparam logic [7:0] ERR_INVALID    = 8'hff;
  // ==========================================
  // management frame constants
  localparam logic [4:0] PHY_STATUS_REG = 5'h01;
  localparam int         MDC_DIV        = 8;
  localparam int         FRAME_BITS     = 64;
  localparam int         TURN_BIT       = 46;
  localparam int         DATA_BIT       = 48;
  // cycles between link polls, 10 ms at 10 MHz
  localparam int         POLL_CYCLES    = 100000;
endpackage

// File: mgmt_master.sv
// clause-22 management frame engine
`timescale 1ns/1ps
module mgmt_master
  import coax_rx_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // request
  input  wire logic        start,
  input  wire logic        isRead,
  input  wire logic [4:0]  phyAddr,
  input  wire logic [4:0]  regAddr,
  input  wire logic [15:0] wrData,
  output logic             busy,
  output logic             done,
  output logic [15:0]      rdData,
  // pins
  output logic             mdc,
  input  wire logic        mdioIn,
  output logic             mdioOut,
  output logic             mdioOeN
);
  localparam int HALF = MDC_DIV / 2;
  initial if (MDC_DIV < 4 || MDC_DIV % 2 != 0) $error("MDC_DIV must be even, >= 4");

  logic [1:0]  divCnt_ff;   // half-period counter
  logic [63:0] shift_ff;    // outgoing frame
  logic [6:0]  bitCnt_ff;   // bits already driven
  logic        rdMode_ff;   // current frame is a read
  logic        inMeta_ff;   // first synchroniser stage
  logic        inSync_ff;   // synchronised data
  logic        edgeEn;      // half-period enable

  assign edgeEn = (divCnt_ff == 2'(HALF - 1));

  // ==========================================
  // mdc divider, eight reference periods
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_ff <= 2'h0;
      mdc       <= 1'b0;
    end else if (edgeEn) begin
      divCnt_ff <= 2'h0;
      mdc       <= ~mdc; // R19
    end else begin
      divCnt_ff <= divCnt_ff + 2'h1;
    end
  end

  // input passes two flops before use
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      inMeta_ff <= 1'b1;
      inSync_ff <= 1'b1;
    end else begin
      inMeta_ff <= mdioIn;
      inSync_ff <= inMeta_ff;
    end
  end

  // ==========================================
  // frame sequencer: drive on falling mdc, sample on rising
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busy      <= 1'b0;
      done      <= 1'b0;
      shift_ff  <= 64'h0;
      bitCnt_ff <= 7'h0;
      rdMode_ff <= 1'b0;
      rdData    <= 16'h0;
      mdioOut   <= 1'b1;
      mdioOeN   <= 1'b1;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        mdioOeN <= 1'b1;
        if (start) begin
          // preamble, start, opcode, addresses, turnaround, data
          shift_ff  <= {32'hffffffff, 2'b01, isRead ? 2'b10 : 2'b01,
                        phyAddr, regAddr, 2'b10, wrData}; // R20 R4
          rdMode_ff <= isRead;
          bitCnt_ff <= 7'h0;
          busy      <= 1'b1;
        end
      end else if (edgeEn && mdc) begin
        if (bitCnt_ff == 7'(FRAME_BITS)) begin
          busy    <= 1'b0;
          done    <= 1'b1;
          mdioOeN <= 1'b1;
        end else begin
          mdioOut   <= shift_ff[63];
          // release for turnaround and read data
          mdioOeN   <= rdMode_ff && (bitCnt_ff >= 7'(TURN_BIT));
          shift_ff  <= {shift_ff[62:0], 1'b0};
          bitCnt_ff <= bitCnt_ff + 7'h1;
        end
      end else if (edgeEn && !mdc && rdMode_ff && bitCnt_ff > 7'(DATA_BIT)) begin
        rdData <= {rdData[14:0], inSync_ff}; // R5
      end
    end
  end
endmodule

// File: fec_err_counter.sv
// windowed error counter for the decoder
`timescale 1ns/1ps
module fec_err_counter
  import coax_rx_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // control
  input  wire logic        restart,
  input  wire logic [7:0]  segCount,
  // decoder events
  input  wire logic        segTick,
  input  wire logic        errTick,
  // result
  output logic [23:0]      errTotal,
  output logic             updated
);
  logic [23:0] segs_ff;   // segments seen in this window
  logic [23:0] errs_ff;   // errors seen in this window
  logic        run_ff;    // window open
  logic [23:0] segLimit;  // window length in segments

  assign segLimit = {segCount, 16'h0000}; // R10

  // ==========================================
  // window counting
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      segs_ff  <= 24'h0;
      errs_ff  <= 24'h0;
      run_ff   <= 1'b0;
      errTotal <= 24'h0;
      updated  <= 1'b0;
    end else if (restart) begin
      segs_ff <= 24'h0;
      errs_ff <= 24'h0;
      run_ff  <= (segCount != 8'h00); // R12
      updated <= 1'b0;                // R12 R16
    end else if (run_ff) begin
      // saturate, never wrap, on a noisy link
      if (errTick && errs_ff != 24'hffffff) begin
        errs_ff <= errs_ff + 24'h1;
      end
      if (segTick) begin
        if (segs_ff + 24'h1 == segLimit) begin
          errTotal <= errs_ff + {23'h0, errTick && errs_ff != 24'hffffff};
          updated  <= 1'b1; // R11
          run_ff   <= 1'b0;
        end
        segs_ff <= segs_ff + 24'h1;
      end
    end
  end
endmodule

// File: coax_rx_mgmt_regs_assertions.sv
// assertions of the coax receiver register bank
`timescale 1ns/1ps
module coax_rx_mgmt_regs_chk
  import coax_rx_pkg::*;
(
  // clock and reset
  input logic       ref_clk,
  input logic       rstn,
  // register port
  input logic       regWrEn,
  input logic       regRdEn,
  input logic [7:0] regAddr,
  input logic [7:0] regWrData,
  input logic [7:0] regRdData,
  // pins and controls
  input logic       mdc,
  input logic       mdioOut,
  input logic       coaxTxEnable,
  input logic       coaxRxEnable,
  input logic [6:0] videoGainField
);
  // ==========================================
  // shadows of written registers
  logic [7:0] ctrl_ff;  // link control as written
  logic [1:0] age_ff;   // cycles since control write, saturating
  logic [7:0] seg_ff;   // segment count as written
  wire        wrCtrl = regWrEn && regAddr == ADDR_LINK_CTRL;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // write shadows; zero count means flag clear, bytes invalid
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= RST_ZERO;
      seg_ff  <= RST_ZERO;
    end else begin
      if (wrCtrl) ctrl_ff <= regWrData;
      if (regWrEn && regAddr == ADDR_FEC_SEGMENTS) seg_ff <= regWrData;
    end
  end
  // settle time after a control write
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) age_ff <= 2'h3;
    else if (wrCtrl) age_ff <= 2'h0;
    else if (age_ff != 2'h3) age_ff <= age_ff + 2'h1;
  end
  // ==========================================
  // assertions
  a_mdc_high_phase:
    assert property ($rose(mdc) |-> mdc [*4] ##1 !mdc) else $error("mdc high");
  a_mdc_low_phase:
    assert property ($fell(mdc) |-> !mdc [*4] ##1 mdc) else $error("mdc low");
  a_mdio_on_fall:
    assert property ($changed(mdioOut) |-> $fell(mdc)) else $error("mdio timing");
  a_gain_write:
    assert property (regWrEn && regAddr == ADDR_VIDEO_GAIN |=> videoGainField == $past(regWrData[6:0]))
      else $error("gain write");
  a_gain_hold:
    assert property (!(regWrEn && regAddr == ADDR_VIDEO_GAIN) |=> $stable(videoGainField))
      else $error("gain moved");
  a_rd_data_hold:
    assert property (!regRdEn |=> $stable(regRdData)) else $error("read data moved");
  a_ctrl_readback:
    assert property (regRdEn && regAddr == ADDR_LINK_CTRL |=> regRdData == ctrl_ff)
      else $error("ctrl readback");
  a_manual_enables:
    assert property (age_ff == 2'h3 && ctrl_ff[CTRL_MANUAL_BIT] |->
      coaxTxEnable == ctrl_ff[CTRL_TX_BIT] && coaxRxEnable == ctrl_ff[CTRL_RX_BIT])
      else $error("manual enables");
  a_auto_pair:
    assert property (age_ff == 2'h3 && !ctrl_ff[CTRL_MANUAL_BIT] |-> coaxTxEnable == coaxRxEnable)
      else $error("auto enables differ");
  a_err_invalid:
    assert property (regRdEn && regAddr inside {8'h40, 8'h41, 8'h42} && seg_ff == 8'h00 |=>
      regRdData == ERR_INVALID) else $error("err not ones");
  // main scenarios reached
  c_mdc_toggle: cover property ($rose(mdc));
  c_manual_mode: cover property (wrCtrl && regWrData[CTRL_MANUAL_BIT]);
  c_err_read: cover property (regRdEn && regAddr == ADDR_FEC_ERR_B0 && seg_ff != 8'h00);
endmodule
bind coax_rx_mgmt_regs coax_rx_mgmt_regs_chk coax_rx_mgmt_regs_chk_i (.ref_clk, .rstn, .regWrEn, .regRdEn,
  .regAddr, .regWrData, .regRdData, .mdc, .mdioOut, .coaxTxEnable, .coaxRxEnable, .videoGainField);

// File: mdio_phy_model.sv
// behavioural management-bus phy
`timescale 1ns/1ps
module mdio_phy_model (
  // bus
  input wire logic         mdc,
  input wire logic         mdioWire,
  output logic             phyOe,
  output logic             phyOut,
  // behaviour and capture
  input wire logic         linkUp,
  input wire logic [15:0]  rdWord,
  output logic [1:0]       lastOp,
  output logic [4:0]       lastPhy,
  output logic [4:0]       lastReg,
  output logic [15:0]      lastData,
  output int               nFrames
);
  int          ones;  // run of preamble ones
  logic [15:0] word;  // shift register
  // sample n bits at rising mdc, msb first
  task automatic take(input int n);
    word = 16'h0000;
    repeat (n) begin
      @(posedge mdc);
      word = {word[14:0], mdioWire};
    end
  endtask
  // frame parser
  initial begin
    {phyOe, phyOut, nFrames, ones} = '0;
    forever begin
      @(posedge mdc);
      if (mdioWire) ones++;
      else if (ones >= 32) begin
        take(1);
        take(2);
        lastOp = word[1:0];
        take(5);
        lastPhy = word[4:0];
        take(5);
        lastReg = word[4:0];
        if (lastOp == 2'b10) begin
          word = (lastReg == 5'h01) ? {13'h0000, linkUp, 2'b00} : rdWord;
          @(negedge mdc);
          @(negedge mdc);
          {phyOe, phyOut} = 2'b10;
          for (int i = 15; i >= 0; i--) begin
            @(negedge mdc);
            phyOut = word[i];
          end
          @(negedge mdc);
          phyOe = 1'b0;
        end else begin
          take(2);
          take(16);
          lastData = word;
        end
        nFrames += (lastReg != 5'h01);  // polls not counted
        ones = 0;
      end else ones = 0;
    end
  end
endmodule

// File: coax_rx_mgmt_regs_tb.sv
// testbench of the coax receiver register bank
`timescale 1ns/1ps
module coax_rx_mgmt_regs_tb_top
  import coax_rx_pkg::*;
();
  localparam int POLL = 600;  // short poll keeps the run brief
  logic        ref_clk = 0, rstn = 0, regWrEn = 0, regRdEn = 0, segTick = 0, errTick = 0, linkUp = 0;
  logic        pinHi, pinLo, mdc, mdioOut, mdioOeN, txEn, rxEn, phyOe, phyOut;
  logic [7:0]  regAddr = 0, regWrData = 0, regRdData, rv, c;
  logic [6:0]  gain;
  logic [15:0] rdWord = 0, lastData, d;
  logic [4:0]  lastPhy, lastReg, r;
  logic [1:0]  lastOp;
  logic [2:0]  p3;
  logic [23:0] nErr;
  int          nFrames, f0, n_mismatch = 0, samples_checked = 0;
  logic [15:0] rstTab [13] = '{16'h1e00, 16'h1f00, 16'h2000, 16'h2100, 16'h2600, 16'h2700, 16'h302b,
                               16'h40ff, 16'h41ff, 16'h42ff, 16'h4300, 16'h4400, 16'h5500};
  wire         mdioWire = !mdioOeN ? mdioOut : (phyOe ? phyOut : 1'b1);  // pull-up when released
  coax_rx_mgmt_regs #(.POLL_PERIOD(POLL)) coax_rx_mgmt_regs_i (.ref_clk, .rstn, .regWrEn, .regRdEn, .regAddr,
    .regWrData, .regRdData, .phyAddrPinHi(pinHi), .phyAddrPinLo(pinLo), .mdc, .mdioIn(mdioWire), .mdioOut,
    .mdioOeN, .fecSegmentTick(segTick), .fecErrorTick(errTick), .coaxTxEnable(txEn), .coaxRxEnable(rxEn),
    .videoGainField(gain));
  mdio_phy_model mdio_phy_model_i (.mdc, .mdioWire, .phyOe, .phyOut, .linkUp, .rdWord, .lastOp, .lastPhy,
    .lastReg, .lastData, .nFrames);
  initial forever #50 ref_clk = ~ref_clk;
  // ==========================================
  // helpers
  function automatic logic [1:0] expEn(input logic [7:0] ctl, input logic lnk);
    return ctl[0] ? {ctl[4], ctl[3]} : {lnk, lnk};
  endfunction
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    #10 {regWrEn, regAddr, regWrData} = {1'b1, a, v};
    @(posedge ref_clk);
    #10 regWrEn = 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    #10 {regRdEn, regAddr} = {1'b1, a};
    @(posedge ref_clk);
    #10 regRdEn = 0;
    rv = regRdData;
  endtask
  // command pulse, bounded wait for its frame
  task automatic mgmtCmd(input logic [3:0] bits);
    f0 = nFrames;
    wr(ADDR_MGMT_CMD, {1'b0, p3, bits});
    wr(ADDR_MGMT_CMD, {1'b0, p3, 4'h0});
    for (int i = 0; i < 3000 && nFrames == f0; i++) @(posedge ref_clk);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #9000000;
    n_mismatch++;
    end_sim();
  end
  // ==========================================
  // tests
  initial begin
    void'($urandom(32'h31816bd1));
    {pinHi, pinLo} = 2'($urandom);
    repeat (8) @(posedge ref_clk);
    #10 rstn = 1;
    foreach (rstTab[i]) begin
      rd(rstTab[i][15:8]);
      chk(rv, rstTab[i][7:0]);
    end
    chk(gain, RST_VIDEO_GAIN);
    $display("reset done");
    for (int i = 0; i < 6; i++) begin
      c = (i == 0) ? 8'h00 : (i == 1) ? 8'h7f : {1'b0, 7'($urandom)};
      wr(ADDR_VIDEO_GAIN, c);
      chk(gain, c[6:0]);
      wr(ADDR_FEC_ERR_B0, 8'($urandom));
      rd(ADDR_FEC_ERR_B0);
      chk(rv, ERR_INVALID);
    end
    $display("gain done");
    p3 = 3'($urandom);
    r = 5'h02 + 5'($urandom_range(29));
    d = 16'($urandom);
    wr(ADDR_MGMT_REG, {3'b000, r});
    wr(ADDR_MGMT_OUT_LO, d[7:0]);
    wr(ADDR_MGMT_OUT_HI, d[15:8]);
    mgmtCmd(4'h2);
    chk(lastOp, 2'b01);
    chk(lastPhy, {p3, pinHi, pinLo});
    chk(lastData, d);
    $display("mdio write done");
    r = 5'h02 + 5'($urandom_range(29));
    rdWord = 16'($urandom);
    wr(ADDR_MGMT_REG, {3'b000, r});
    mgmtCmd(4'h1);
    chk(lastReg, r);
    repeat (16) @(posedge ref_clk);
    rd(ADDR_MGMT_IN_LO);
    chk(rv, rdWord[7:0]);
    rd(ADDR_MGMT_IN_HI);
    chk(rv, rdWord[15:8]);
    $display("mdio read done");
    wr(ADDR_LINK_CTRL, 8'h06);
    for (int k = 1; k >= 0; k--) begin
      linkUp = 1'(k);
      repeat (3 * POLL) @(posedge ref_clk);
      rd(ADDR_STATUS);
      chk(rv[STATUS_LINK_BIT], linkUp);
      chk({rxEn, txEn}, expEn(8'h06, linkUp));
    end
    for (int k = 0; k < 4; k++) begin
      c = {3'b000, 2'(k), 3'b111};
      wr(ADDR_LINK_CTRL, c);
      repeat (3) @(posedge ref_clk);
      chk({rxEn, txEn}, expEn(c, linkUp));
    end
    $display("link done");
    wr(ADDR_FEC_SEGMENTS, 8'h01);
    nErr = 0;
    for (int i = 0; i < 65536; i++) begin
      @(posedge ref_clk);
      #10 {segTick, errTick} = {1'b1, (i > 0 && i < 65535) ? 1'($urandom) : 1'b0};
      nErr += errTick;
      if (i == 65534) begin
        @(posedge ref_clk);
        #10 {segTick, errTick} = 2'b00;
        rd(ADDR_FEC_UPDATED);
        chk(rv, 8'h00);
      end
    end
    @(posedge ref_clk);
    #10 {segTick, errTick} = 2'b00;
    repeat (4) @(posedge ref_clk);
    rd(ADDR_FEC_UPDATED);
    chk(rv, 8'h01);
    for (int b = 0; b < 3; b++) begin
      rd(ADDR_FEC_ERR_B0 + 8'(b));
      chk(rv, nErr[8 * b +: 8]);
    end
    wr(ADDR_FEC_SEGMENTS, 8'h00);
    rd(ADDR_FEC_UPDATED);
    chk(rv, 8'h00);
    rd(ADDR_FEC_ERR_B2);
    chk(rv, ERR_INVALID);
    $display("counter done");
    end_sim();
  end
endmodule
